/* File: include/acr_pkg.sv */
// constants and types shared by the converter configuration bank
package acr_pkg;

    // ========================================================
    // register indices (byte address is four times the index)
    localparam logic [5:0] ACR_IDX_RATE_MODE = 6'h01;
    localparam logic [5:0] ACR_IDX_STATUS_CHECK = 6'h02;
    localparam logic [5:0] ACR_IDX_ROUTING = 6'h03;
    localparam logic [5:0] ACR_IDX_IRQ_STATUS = 6'h04;
    localparam logic [5:0] ACR_IDX_IRQ_CLEAR = 6'h05;
    localparam logic [5:0] ACR_IDX_IRQ_ENABLE = 6'h06;
    localparam logic [5:0] ACR_IDX_COUNTER = 6'h07;

    // ========================================================
    // reset values
    localparam logic [7:0] ACR_RST_RATE_MODE = 8'h00;
    localparam logic [7:0] ACR_RST_STATUS_CHECK = 8'h00;
    localparam logic [7:0] ACR_RST_ROUTING = 8'h00;
    localparam logic [1:0] ACR_RST_IRQ = 2'h0;
    localparam logic [7:0] ACR_RST_COUNTER = 8'h00;
    localparam logic [10:0] ACR_RST_SPS = 11'h014;

    // ========================================================
    // field positions, rate / mode / reference register
    localparam int ACR_RATE_MSB = 7;
    localparam int ACR_RATE_LSB = 5;
    localparam int ACR_TURBO_BIT = 4;
    localparam int ACR_CONT_BIT = 3;
    localparam int ACR_REF_MSB = 2;
    localparam int ACR_REF_LSB = 1;
    localparam int ACR_TEMP_BIT = 0;

    // field positions, status / check / current register
    localparam int ACR_READY_BIT = 7;
    localparam int ACR_COUNT_EN_BIT = 6;
    localparam int ACR_CHECK_MSB = 5;
    localparam int ACR_CHECK_LSB = 4;
    localparam int ACR_BURNOUT_BIT = 3;
    localparam int ACR_MAG_MSB = 2;
    localparam int ACR_MAG_LSB = 0;

    // field positions, routing / output register
    localparam int ACR_ONE_MSB = 7;
    localparam int ACR_ONE_LSB = 5;
    localparam int ACR_TWO_MSB = 4;
    localparam int ACR_TWO_LSB = 2;
    localparam int ACR_RSVD_BIT = 1;
    localparam int ACR_AUTO_BIT = 0;

    // interrupt status bits
    localparam int ACR_IRQ_RESULT = 0;
    localparam int ACR_IRQ_BAD_CODE = 1;

    // ========================================================
    // encodings
    localparam logic [1:0] ACR_REF_INTERNAL = 2'h0;
    localparam logic [1:0] ACR_REF_EXTERNAL = 2'h1;
    localparam logic [1:0] ACR_REF_SUPPLY = 2'h2;
    localparam logic [2:0] ACR_CODE_RESERVED = 3'h7;
    localparam logic [1:0] ACR_CHECK_RESERVED = 2'h3;

    typedef enum logic [0:0] {
        ACR_BUS_IDLE = 1'b0,
        ACR_BUS_ACK = 1'b1
    } acr_bus_type;

endpackage

/* File: hdl/acr_route_decode.sv */
// decoder of one excitation source routing code
`timescale 1ns/1ps

module acr_route_decode
(
    // routing code
    input wire logic [2:0] i_code,
    // one-hot target: inputs 0..3, positive ref, negative ref
    output logic [5:0] o_target,
    output logic o_reserved
);

    // ========================================================
    // decode
    always_comb
    begin
        o_target = 6'h00;
        o_reserved = 1'b0;
        case (i_code)
            3'h0:
            begin
                o_target = 6'h00;
            end
            3'h1:
            begin
                o_target = 6'h01;
            end
            3'h2:
            begin
                o_target = 6'h02;
            end
            3'h3:
            begin
                o_target = 6'h04;
            end
            3'h4:
            begin
                o_target = 6'h08;
            end
            3'h5:
            begin
                o_target = 6'h10;
            end
            3'h6:
            begin
                o_target = 6'h20;
            end
            default:
            begin
                o_reserved = 1'b1;
            end
        endcase
    end

endmodule

/* File: hdl/acr_config_bank.sv */
// configuration register bank of the converter, reached over APB
//
// Operation
// - rate code bits 7:5 picks 20 to 1000 samples/s; code 7 reserved
// - bit 4 set gives turbo, 512 kHz clock, doubled rate up to 2000
// - bit 3 picks single-shot when clear, continuous when set
// - bits 2:1 pick internal, external, or supply reference
// - bit 0 enables temperature sensor measurement mode
// - temperature mode ignores register 0 and forces internal reference
// - ready flag sets on new result, clears when data are read
// - bit 6 enables the conversion data counter
// - bits 5:4 pick none, inverted copy, or CRC16 check
// - bit 3 switches the burn-out current sources on
// - bits 2:0 set common excitation current, off to 1000 uA
// - bits 7:5 route the first excitation source
// - bits 4:2 route the second excitation source, same encoding
// - bit 1 of routing register reads zero; host writes zero
// - bit 0 sends results automatically, else only on host read
// - registers 2 and 3 at indices 2, 3, reset to zero
// - register 1 at index 1, reset to zero
`timescale 1ns/1ps

module acr_config_bank
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_NRST,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // converter events
    input wire logic I_RESULT_DONE,
    input wire logic I_RESULT_READ,
    // conversion setup
    output logic [10:0] O_RATE_SPS,
    output logic O_RATE_RESERVED,
    output logic O_TURBO,
    output logic O_CONTINUOUS,
    output logic [1:0] O_REF_SEL,
    output logic O_TEMP_SENSOR_ENABLE,
    output logic O_CFG0_IGNORE,
    // data path setup
    output logic O_RESULT_READY_FLAG,
    output logic O_COUNTER_ENABLE,
    output logic [1:0] O_INTEGRITY_MODE,
    output logic O_BURNOUT_ENABLE,
    output logic [9:0] O_EXCITATION_UA,
    output logic [5:0] O_ROUTE_ONE,
    output logic [5:0] O_ROUTE_TWO,
    output logic O_AUTO_SEND,
    output logic O_SEND_RESULT,
    // interrupt
    output logic O_IRQ
);

    // ========================================================
    // helpers
    function automatic logic [10:0] rate_sps(input logic [2:0] code,
                                             input logic turbo);
        logic [10:0] base;
        base = 11'h000;
        case (code)
            3'h0: base = 11'h014;
            3'h1: base = 11'h02d;
            3'h2: base = 11'h05a;
            3'h3: base = 11'h0af;
            3'h4: base = 11'h14a;
            3'h5: base = 11'h258;
            3'h6: base = 11'h3e8;
            default: base = 11'h000;
        endcase
        rate_sps = turbo ? {base[9:0], 1'b0} : base;
    endfunction

    function automatic logic [9:0] magnitude_ua(input logic [2:0] code);
        case (code)
            3'h1: magnitude_ua = 10'h00a;
            3'h2: magnitude_ua = 10'h032;
            3'h3: magnitude_ua = 10'h064;
            3'h4: magnitude_ua = 10'h0fa;
            3'h5: magnitude_ua = 10'h1f4;
            3'h6: magnitude_ua = 10'h3e8;
            default: magnitude_ua = 10'h000;
        endcase
    endfunction

    // ========================================================
    // state
    typedef struct packed {
        acr_pkg::acr_bus_type bus;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] rate_mode;
        logic [6:0] check_current;
        logic ready;
        logic [7:0] routing;
        logic [1:0] irq_status;
        logic [1:0] irq_enable;
        logic [7:0] counter;
        logic [10:0] sps;
        logic rate_rsvd;
        logic [1:0] ref_sel;
        logic [9:0] ua;
        logic [5:0] route_one;
        logic [5:0] route_two;
        logic send;
        logic irq;
    } acr_state_type;

    acr_state_type r;
    acr_state_type next_r;

    logic [5:0] dec_one;
    logic [5:0] dec_two;
    logic rsvd_one;
    logic rsvd_two;

    // ========================================================
    // routing decoders
    acr_route_decode u_route_one
    (
        .i_code(next_r.routing[acr_pkg::ACR_ONE_MSB:acr_pkg::ACR_ONE_LSB]),
        .o_target(dec_one),
        .o_reserved(rsvd_one)
    );

    acr_route_decode u_route_two
    (
        .i_code(next_r.routing[acr_pkg::ACR_TWO_MSB:acr_pkg::ACR_TWO_LSB]),
        .o_target(dec_two),
        .o_reserved(rsvd_two)
    );

    // ========================================================
    // next state
    always_comb
    begin
        logic [5:0] idx;
        logic aligned;
        logic mapped;
        logic commit;
        logic [7:0] rd;
        logic [7:0] wd;
        logic bad_code;
        logic [1:0] events;
        logic [1:0] clr;
        idx = I_PADDR[7:2];
        aligned = (I_PADDR[1:0] == 2'h0);
        wd = I_PWDATA[7:0];
        rd = 8'h00;
        bad_code = 1'b0;
        clr = 2'h0;
        mapped = 1'b0;
        events = 2'h0;
        commit = 1'b0;
        next_r = r;
        next_r.send = 1'b0;
        case (idx)
            acr_pkg::ACR_IDX_RATE_MODE: mapped = aligned;
            acr_pkg::ACR_IDX_STATUS_CHECK: mapped = aligned;
            acr_pkg::ACR_IDX_ROUTING: mapped = aligned;
            acr_pkg::ACR_IDX_IRQ_STATUS: mapped = aligned;
            acr_pkg::ACR_IDX_IRQ_CLEAR: mapped = aligned;
            acr_pkg::ACR_IDX_IRQ_ENABLE: mapped = aligned;
            acr_pkg::ACR_IDX_COUNTER: mapped = aligned;
            default: mapped = 1'b0;
        endcase
        // read mux
        case (idx)
            acr_pkg::ACR_IDX_RATE_MODE: rd = r.rate_mode;
            acr_pkg::ACR_IDX_STATUS_CHECK: rd = {r.ready, r.check_current};
            acr_pkg::ACR_IDX_ROUTING: rd = {r.routing[7:2], 1'b0,
                                            r.routing[0]};
            acr_pkg::ACR_IDX_IRQ_STATUS: rd = {6'h00, r.irq_status};
            acr_pkg::ACR_IDX_IRQ_ENABLE: rd = {6'h00, r.irq_enable};
            acr_pkg::ACR_IDX_COUNTER: rd = r.counter;
            default: rd = 8'h00;
        endcase
        // bus phases: setup loads answer, access commits
        case (r.bus)
            acr_pkg::ACR_BUS_IDLE:
            begin
                if (I_PSEL && !I_PENABLE)
                begin
                    next_r.bus = acr_pkg::ACR_BUS_ACK;
                    next_r.pready = 1'b1;
                    next_r.pslverr = !mapped;
                    next_r.prdata = (I_PWRITE || !mapped) ? 32'h0000_0000
                                    : {24'h00_0000, rd};
                end
            end
            acr_pkg::ACR_BUS_ACK:
            begin
                next_r.bus = acr_pkg::ACR_BUS_IDLE;
                next_r.pready = 1'b0;
                next_r.pslverr = 1'b0;
                commit = I_PSEL && I_PENABLE && I_PWRITE && mapped;
            end
            default:
            begin
                next_r.bus = acr_pkg::ACR_BUS_IDLE;
                next_r.pready = 1'b0;
            end
        endcase
        if (commit)
        begin
            case (idx)
                acr_pkg::ACR_IDX_RATE_MODE:
                begin
                    next_r.rate_mode = wd;
                    bad_code = (wd[acr_pkg::ACR_RATE_MSB:
                                   acr_pkg::ACR_RATE_LSB]
                                == acr_pkg::ACR_CODE_RESERVED);
                end
                acr_pkg::ACR_IDX_STATUS_CHECK:
                begin
                    next_r.check_current = wd[6:0];
                    bad_code = (wd[acr_pkg::ACR_CHECK_MSB:
                                   acr_pkg::ACR_CHECK_LSB]
                                == acr_pkg::ACR_CHECK_RESERVED)
                               || (wd[acr_pkg::ACR_MAG_MSB:
                                      acr_pkg::ACR_MAG_LSB]
                                   == acr_pkg::ACR_CODE_RESERVED);
                end
                acr_pkg::ACR_IDX_ROUTING:
                begin
                    next_r.routing = {wd[7:2], 1'b0, wd[0]};
                    bad_code = (wd[acr_pkg::ACR_ONE_MSB:
                                   acr_pkg::ACR_ONE_LSB]
                                == acr_pkg::ACR_CODE_RESERVED)
                               || (wd[acr_pkg::ACR_TWO_MSB:
                                      acr_pkg::ACR_TWO_LSB]
                                   == acr_pkg::ACR_CODE_RESERVED);
                end
                acr_pkg::ACR_IDX_IRQ_CLEAR: clr = wd[1:0];
                acr_pkg::ACR_IDX_IRQ_ENABLE: next_r.irq_enable = wd[1:0];
                default: clr = 2'h0;
            endcase
        end
        // ready flag, set wins over read
        if (I_RESULT_DONE)
        begin
            next_r.ready = 1'b1;
        end
        else if (I_RESULT_READ)
        begin
            next_r.ready = 1'b0;
        end
        // conversion counter
        if (I_RESULT_DONE && r.check_current[acr_pkg::ACR_COUNT_EN_BIT])
        begin
            next_r.counter = r.counter + 8'h01;
        end
        // automatic result output
        next_r.send = I_RESULT_DONE
                      && r.routing[acr_pkg::ACR_AUTO_BIT];
        // sticky interrupt status, set wins over clear
        events[acr_pkg::ACR_IRQ_RESULT] = I_RESULT_DONE;
        events[acr_pkg::ACR_IRQ_BAD_CODE] = bad_code;
        next_r.irq_status = (r.irq_status & ~clr) | events;
        next_r.irq = |(next_r.irq_status & next_r.irq_enable);
        // decoded setup
        next_r.sps = rate_sps(next_r.rate_mode[acr_pkg::ACR_RATE_MSB:
                                               acr_pkg::ACR_RATE_LSB],
                              next_r.rate_mode[acr_pkg::ACR_TURBO_BIT]);
        next_r.rate_rsvd = (next_r.rate_mode[acr_pkg::ACR_RATE_MSB:
                                             acr_pkg::ACR_RATE_LSB]
                            == acr_pkg::ACR_CODE_RESERVED);
        if (next_r.rate_mode[acr_pkg::ACR_TEMP_BIT])
        begin
            next_r.ref_sel = acr_pkg::ACR_REF_INTERNAL;
        end
        else
        begin
            case (next_r.rate_mode[acr_pkg::ACR_REF_MSB:
                                   acr_pkg::ACR_REF_LSB])
                2'h0: next_r.ref_sel = acr_pkg::ACR_REF_INTERNAL;
                2'h1: next_r.ref_sel = acr_pkg::ACR_REF_EXTERNAL;
                default: next_r.ref_sel = acr_pkg::ACR_REF_SUPPLY;
            endcase
        end
        next_r.ua = magnitude_ua(next_r.check_current[acr_pkg::ACR_MAG_MSB:
                                                      acr_pkg::ACR_MAG_LSB]);
        next_r.route_one = dec_one;
        next_r.route_two = dec_two;
        if (rsvd_one || rsvd_two)
        begin
            next_r.route_one = rsvd_one ? 6'h00 : dec_one;
            next_r.route_two = rsvd_two ? 6'h00 : dec_two;
        end
    end

    // ========================================================
    // registers
    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            r.bus <= acr_pkg::ACR_BUS_IDLE;
            r.prdata <= 32'h0000_0000;
            r.pready <= 1'b0;
            r.pslverr <= 1'b0;
            r.rate_mode <= acr_pkg::ACR_RST_RATE_MODE;
            r.check_current <= acr_pkg::ACR_RST_STATUS_CHECK[6:0];
            r.ready <= acr_pkg::ACR_RST_STATUS_CHECK[7];
            r.routing <= acr_pkg::ACR_RST_ROUTING;
            r.irq_status <= acr_pkg::ACR_RST_IRQ;
            r.irq_enable <= acr_pkg::ACR_RST_IRQ;
            r.counter <= acr_pkg::ACR_RST_COUNTER;
            r.sps <= acr_pkg::ACR_RST_SPS;
            r.rate_rsvd <= 1'b0;
            r.ref_sel <= acr_pkg::ACR_REF_INTERNAL;
            r.ua <= 10'h000;
            r.route_one <= 6'h00;
            r.route_two <= 6'h00;
            r.send <= 1'b0;
            r.irq <= 1'b0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ========================================================
    // outputs
    assign O_PRDATA = r.prdata;
    assign O_PREADY = r.pready;
    assign O_PSLVERR = r.pslverr;
    assign O_RATE_SPS = r.sps;
    assign O_RATE_RESERVED = r.rate_rsvd;
    assign O_TURBO = r.rate_mode[acr_pkg::ACR_TURBO_BIT];
    assign O_CONTINUOUS = r.rate_mode[acr_pkg::ACR_CONT_BIT];
    assign O_REF_SEL = r.ref_sel;
    assign O_TEMP_SENSOR_ENABLE = r.rate_mode[acr_pkg::ACR_TEMP_BIT];
    assign O_CFG0_IGNORE = r.rate_mode[acr_pkg::ACR_TEMP_BIT];
    assign O_RESULT_READY_FLAG = r.ready;
    assign O_COUNTER_ENABLE = r.check_current[acr_pkg::ACR_COUNT_EN_BIT];
    assign O_INTEGRITY_MODE = r.check_current[acr_pkg::ACR_CHECK_MSB:
                                              acr_pkg::ACR_CHECK_LSB];
    assign O_BURNOUT_ENABLE = r.check_current[acr_pkg::ACR_BURNOUT_BIT];
    assign O_EXCITATION_UA = r.ua;
    assign O_ROUTE_ONE = r.route_one;
    assign O_ROUTE_TWO = r.route_two;
    assign O_AUTO_SEND = r.routing[acr_pkg::ACR_AUTO_BIT];
    assign O_SEND_RESULT = r.send;
    assign O_IRQ = r.irq;

endmodule

/* File: testbench/acr_config_bank_properties.sv */
// assertion checker for the configuration bank ports
`timescale 1ns/1ps

module acr_config_bank_properties
(
    // clock, reset and bus
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic [7:0] I_PADDR,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    // converter events
    input wire logic I_RESULT_DONE,
    input wire logic I_RESULT_READ,
    input wire logic O_RESULT_READY_FLAG,
    input wire logic O_AUTO_SEND,
    input wire logic O_SEND_RESULT,
    // conversion setup
    input wire logic [10:0] O_RATE_SPS,
    input wire logic O_RATE_RESERVED,
    input wire logic O_TURBO,
    input wire logic [1:0] O_REF_SEL,
    input wire logic O_TEMP_SENSOR_ENABLE,
    input wire logic O_CFG0_IGNORE
);
    // ====================================
    // properties
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_NRST);

    a_ready_set:
    assert property (I_RESULT_DONE |=> O_RESULT_READY_FLAG)
        else $error("ready flag not set after result");
    a_ready_clear:
    assert property (I_RESULT_READ && !I_RESULT_DONE |=> !O_RESULT_READY_FLAG)
        else $error("ready flag not cleared by data read");
    a_ready_hold:
    assert property (!I_RESULT_DONE && !I_RESULT_READ
        |=> $stable(O_RESULT_READY_FLAG))
        else $error("ready flag moved without event");
    a_send_auto:
    assert property (I_RESULT_DONE && O_AUTO_SEND |=> O_SEND_RESULT)
        else $error("automatic send missing");
    a_send_cause:
    assert property (O_SEND_RESULT |-> $past(I_RESULT_DONE))
        else $error("send without finished result");
    a_temp_ref:
    assert property (O_TEMP_SENSOR_ENABLE
        |-> O_REF_SEL == 2'h0 && O_CFG0_IGNORE)
        else $error("temperature mode not forcing internal reference");
    a_rate_rsvd:
    assert property (O_RATE_RESERVED |-> O_RATE_SPS == 11'h000)
        else $error("reserved rate gives nonzero rate");
    a_rate_normal:
    assert property (!O_TURBO && !O_RATE_RESERVED
        |-> O_RATE_SPS inside {11'h014, 11'h02d, 11'h05a, 11'h0af,
        11'h14a, 11'h258, 11'h3e8})
        else $error("normal rate outside table");
    a_rate_turbo:
    assert property (O_TURBO && !O_RATE_RESERVED
        |-> O_RATE_SPS inside {11'h028, 11'h05a, 11'h0b4, 11'h15e,
        11'h294, 11'h4b0, 11'h7d0})
        else $error("turbo rate outside table");
    a_zero_wait:
    assert property (I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY)
        else $error("bus answer not in access cycle");
    a_err_unmapped:
    assert property (O_PREADY && I_PADDR[7:2] > 6'h07 |-> O_PSLVERR)
        else $error("unmapped address without error");
    c_send: cover property (I_RESULT_DONE && O_AUTO_SEND);
    c_temp: cover property (O_TEMP_SENSOR_ENABLE);
    c_err: cover property (O_PSLVERR);
endmodule

bind acr_config_bank acr_config_bank_properties i_props (.I_CLK(I_CLK),
    .I_NRST(I_NRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PADDR(I_PADDR), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_RESULT_DONE(I_RESULT_DONE), .I_RESULT_READ(I_RESULT_READ),
    .O_RESULT_READY_FLAG(O_RESULT_READY_FLAG), .O_AUTO_SEND(O_AUTO_SEND),
    .O_SEND_RESULT(O_SEND_RESULT), .O_RATE_SPS(O_RATE_SPS),
    .O_RATE_RESERVED(O_RATE_RESERVED), .O_TURBO(O_TURBO),
    .O_REF_SEL(O_REF_SEL), .O_TEMP_SENSOR_ENABLE(O_TEMP_SENSOR_ENABLE),
    .O_CFG0_IGNORE(O_CFG0_IGNORE));

/* File: testbench/acr_conv_model.sv */
// converter side model: result pulses and data reads
`timescale 1ns/1ps

module acr_conv_model
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // bench commands
    input wire logic i_start,
    input wire logic i_auto_read,
    input wire logic [3:0] i_read_lat,
    // device side
    input wire logic i_ready_flag,
    output logic o_done,
    output logic o_read
);
    // ====================================
    // one result per start, data read after a delay
    logic [3:0] cnt;
    always_ff @(posedge i_clk)
    begin
        o_done <= i_nrst & i_start;
        o_read <= 1'b0;
        if (!i_nrst || !i_auto_read || !i_ready_flag || o_read)
            cnt <= 4'h0;
        else if (cnt == i_read_lat)
        begin
            o_read <= 1'b1;
            cnt <= 4'h0;
        end
        else
            cnt <= cnt + 4'h1;
    end
endmodule

/* File: testbench/acr_config_bank_tb.sv */
// self-checking bench of the converter configuration bank
`timescale 1ns/1ps

module acr_config_bank_tb;
    // ====================================
    // signals
    logic clk, nrst, psel, penable, pwrite, start, auto_rd, done, rdp;
    logic pready, pslverr, err, rsvd, turbo, cont, temp, ign, ready;
    logic cnt_en, burn, autos, send, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [10:0] sps;
    logic [1:0] refs, integ;
    logic [9:0] ua;
    logic [5:0] r1, r2;
    logic [3:0] lat;
    int n_fail = 0;
    int n_checks = 0;
    int n_send = 0;
    int n;

    acr_config_bank i_dut (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_RESULT_DONE(done), .I_RESULT_READ(rdp),
        .O_RATE_SPS(sps), .O_RATE_RESERVED(rsvd), .O_TURBO(turbo),
        .O_CONTINUOUS(cont), .O_REF_SEL(refs), .O_TEMP_SENSOR_ENABLE(temp),
        .O_CFG0_IGNORE(ign), .O_RESULT_READY_FLAG(ready),
        .O_COUNTER_ENABLE(cnt_en), .O_INTEGRITY_MODE(integ),
        .O_BURNOUT_ENABLE(burn), .O_EXCITATION_UA(ua), .O_ROUTE_ONE(r1),
        .O_ROUTE_TWO(r2), .O_AUTO_SEND(autos), .O_SEND_RESULT(send),
        .O_IRQ(irq));
    acr_conv_model i_conv (.i_clk(clk), .i_nrst(nrst), .i_start(start),
        .i_auto_read(auto_rd), .i_read_lat(lat), .i_ready_flag(ready),
        .o_done(done), .o_read(rdp));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
        if (send === 1'b1)
            n_send <= n_send + 1;

    // ====================================
    // expectations and tasks
    function automatic logic [10:0] rate_of(input int c, input int t);
        logic [10:0] tab [8];
        tab = '{11'h014, 11'h02d, 11'h05a, 11'h0af, 11'h14a, 11'h258,
            11'h3e8, 11'h000};
        return tab[c] << t;
    endfunction

    function automatic logic [9:0] ua_of(input int c);
        logic [9:0] tab [8];
        tab = '{10'h000, 10'h00a, 10'h032, 10'h064, 10'h0fa, 10'h1f4,
            10'h3e8, 10'h000};
        return tab[c];
    endfunction

    function automatic logic [5:0] route_of(input int c);
        return (c >= 1 && c <= 6) ? 6'h01 << (c - 1) : 6'h00;
    endfunction

    task automatic close_out;
    begin
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
    begin
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        if (k >= 16)
        begin
            n_fail++;
            $display("[ERR] %0t bus answer timeout", $time);
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    begin
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    end
    endtask

    task automatic pulse;
    begin
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (4) @(posedge clk);
    end
    endtask

    // ====================================
    // main sequence
    initial
    begin
        {nrst, psel, penable, pwrite, start, auto_rd} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        lat = 4'h0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(sps, 32'h14);
        rdc(8'h04, 32'h0);
        rdc(8'h08, 32'h0);
        rdc(8'h0c, 32'h0);
        for (int t = 0; t < 2; t++)
            for (int c = 0; c < 8; c++)
            begin
                wr(8'h04, {24'h0, c[2:0], t[0], 4'h0});
                chk(sps, rate_of(c, t));
                chk(turbo, t[0]);
                chk(rsvd, c == 7);
            end
        rdc(8'h10, 32'h2);
        for (int r = 0; r < 4; r++)
        begin
            wr(8'h04, {28'h0, 1'b1, r[1:0], 1'b0});
            chk(cont, 1'b1);
            chk(refs, (r == 3) ? 2'h2 : r[1:0]);
        end
        wr(8'h04, 32'h07);
        chk({temp, ign, refs}, 4'hc);
        rdc(8'h04, 32'h07);
        wr(8'h04, 32'h00);
        chk({cont, temp}, 2'h0);
        for (int m = 0; m < 8; m++)
        begin
            v = {24'h0, 1'b1, m[0], m[1:0], m[0], m[2:0]};
            wr(8'h08, v);
            chk({cnt_en, integ, burn}, {m[0], m[1:0], m[0]});
            chk(ua, ua_of(m));
            rdc(8'h08, v & 32'h7f);
        end
        for (int c = 0; c < 8; c++)
        begin
            v = {24'h0, c[2:0], 3'(7 - c), 1'b0, c[0]};
            wr(8'h0c, v);
            chk(r1, route_of(c));
            chk(r2, route_of(7 - c));
            chk(autos, c[0]);
            rdc(8'h0c, v & 32'hfd);
        end
        wr(8'h14, 32'h3);
        wr(8'h18, 32'h1);
        wr(8'h08, 32'h40);
        wr(8'h0c, 32'h01);
        rdc(8'h1c, 32'h0);
        pulse();
        chk({ready, irq}, 2'h3);
        chk(n_send, 1);
        rdc(8'h1c, 32'h1);
        rdc(8'h08, 32'hc0);
        wr(8'h18, 32'h0);
        @(posedge clk);
        chk(irq, 1'b0);
        wr(8'h14, 32'h1);
        rdc(8'h10, 32'h0);
        lat <= 4'h3;
        auto_rd <= 1'b1;
        n = 0;
        while (ready === 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        chk(ready, 1'b0);
        if (n >= 20)
        begin
            close_out();
        end
        auto_rd <= 1'b0;
        wr(8'h08, 32'h00);
        wr(8'h0c, 32'h00);
        pulse();
        rdc(8'h1c, 32'h1);
        chk({ready, n_send[1:0]}, 3'h5);
        apb(1'b1, 8'h20, 32'h0);
        chk(err, 1'b1);
        apb(1'b0, 8'h05, 32'h0);
        chk(err, 1'b1);
        close_out();
    end
endmodule
